// >>> logic/ext_pin_change_irq_defines.svh
// Register indices, field widths and reset values of the interrupt block
`ifndef EXT_PIN_CHANGE_IRQ_DEFINES_SVH
`define EXT_PIN_CHANGE_IRQ_DEFINES_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define IDX_PIN_CHANGE_FLAGS 8'h3B
`define IDX_EXTERNAL_LINE_FLAGS 8'h3C
`define IDX_EXTERNAL_LINE_MASK 8'h3D
`define IDX_PIN_CHANGE_GROUP_ENABLE 8'h68
`define IDX_EXTERNAL_SENSE_CONTROL 8'h69
`define IDX_PIN_CHANGE_MASK_LOW 8'h6B
`define IDX_PIN_CHANGE_MASK_MID 8'h6C
`define IDX_PIN_CHANGE_MASK_HIGH 8'h6D

// ------------------------------------------------------------
// Field widths and reset values
// ------------------------------------------------------------
`define WB_ADR_W 10
`define EXT_LINES 2
`define PC_GROUPS 3
`define PC_PINS 24
`define MASK_MID_W 7
`define RST_BYTE 8'h00
`define RST_EXT 2'h0
`define RST_SENSE 4'h0
`define RST_GROUPS 3'h0
`define RST_MASK_MID 7'h00

`endif

// >>> logic/ext_pin_change_irq_pkg.sv
// Types shared by the external and pin-change interrupt block
`default_nettype none

package ext_pin_change_irq_pkg;

  // Sense-control encoding of one external line
  typedef enum logic [1:0] {
    SENSE_LOW_LEVEL = 2'h0,
    SENSE_ANY_CHANGE = 2'h1,
    SENSE_FALLING = 2'h2,
    SENSE_RISING = 2'h3
  } sense_t;

  // One bit per interrupt vector, each with its own entry
  typedef struct packed {
    logic group_two_vector;
    logic group_one_vector;
    logic group_zero_vector;
    logic ext_line_one;
    logic ext_line_zero;
  } irq_vec_t;

endpackage : ext_pin_change_irq_pkg

`default_nettype wire

// >>> logic/ext_pin_change_irq.sv
// External line and pin-change interrupt flags, masks and requests
//
// What this block does
// - Unused upper bits of mask, flag and control registers read zero.
// - Line one requests only with its mask bit and global enable set.
// - Line zero requests only with its mask bit and global enable set.
// - Two sense bits per line pick rising, falling, any edge or low level.
// - Pin activity requests even when the pin is driven as an output.
// - A qualifying edge on line one or zero sets its flag bit.
// - Flag, mask and global enable all set drive that line's vector.
// - Entering a vector clears that vector's flag.
// - Writing one clears a flag bit; writing zero leaves it.
// - A line in low-level sensing reads its flag as zero.
// - Each external line has its own vector.
// - Group two (inputs 23..16) needs its enable bit and global enable.
// - Group one (inputs 14..8) needs its enable bit and global enable.
// - Group zero (inputs 7..0) needs its enable bit and global enable.
// - A change on an enabled input of a group sets that group's flag.
// - Each pin-change group has its own vector.
// - High mask bits enable inputs 23..16 one by one.
// - Mid mask bits 6..0 enable inputs 14..8; bit 7 reads zero.
// - Low mask bits enable inputs 7..0 one by one.
// - Sense code 00 low, 01 any change, 10 falling, 11 rising.
// - Lines are sampled before edge detection; one-cycle pulses are caught.
// - Low-level sensing keeps requesting while the pin stays low.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "ext_pin_change_irq_defines.svh"

module ext_pin_change_irq (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Processor core
  input wire logic global_irq_enable_i,
  input wire ext_pin_change_irq_pkg::irq_vec_t vector_entry_i,
  output var ext_pin_change_irq_pkg::irq_vec_t irq_request_o,
  // Pins
  input wire logic ext_line_zero_i,
  input wire logic ext_line_one_i,
  input wire logic [`PC_PINS-1:0] pin_change_input_i
);

  // ------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] reg_index(input logic [`WB_ADR_W-1:0] adr);
    reg_index = adr[9:2];
  endfunction : reg_index

  function automatic logic sense_trigger(input logic [1:0] sense, input logic cur,
                                         input logic prev);
    unique case (sense)
      ext_pin_change_irq_pkg::SENSE_ANY_CHANGE: sense_trigger = cur ^ prev;
      ext_pin_change_irq_pkg::SENSE_FALLING: sense_trigger = prev & ~cur;
      ext_pin_change_irq_pkg::SENSE_RISING: sense_trigger = cur & ~prev;
      default: sense_trigger = 1'b0;
    endcase
  endfunction : sense_trigger

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [`EXT_LINES-1:0] external_line_mask;
  logic [`EXT_LINES-1:0] external_line_flags;
  logic [2*`EXT_LINES-1:0] external_sense_control;
  logic [`PC_GROUPS-1:0] pin_change_group_enable;
  logic [`PC_GROUPS-1:0] pin_change_flags;
  logic [7:0] pin_change_mask_high;
  logic [`MASK_MID_W-1:0] pin_change_mask_mid;
  logic [7:0] pin_change_mask_low;

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  logic bus_req;
  logic bus_wr;
  logic [7:0] bus_idx;
  logic [7:0] wr_byte;
  logic [31:0] next_rd_data;

  // Ack is registered, so every access answers one cycle after it is seen
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  assign bus_idx = reg_index(wb_adr_i);
  assign wr_byte = wb_dat_i[7:0];

  always_comb begin
    next_rd_data = 32'h0000_0000;
    unique case (bus_idx)
      `IDX_EXTERNAL_LINE_MASK: next_rd_data[`EXT_LINES-1:0] = external_line_mask;
      `IDX_EXTERNAL_LINE_FLAGS: next_rd_data[`EXT_LINES-1:0] = external_line_flags;
      `IDX_EXTERNAL_SENSE_CONTROL: next_rd_data[3:0] = external_sense_control;
      `IDX_PIN_CHANGE_GROUP_ENABLE: next_rd_data[2:0] = pin_change_group_enable;
      `IDX_PIN_CHANGE_FLAGS: next_rd_data[2:0] = pin_change_flags;
      `IDX_PIN_CHANGE_MASK_HIGH: next_rd_data[7:0] = pin_change_mask_high;
      `IDX_PIN_CHANGE_MASK_MID: next_rd_data[6:0] = pin_change_mask_mid;
      `IDX_PIN_CHANGE_MASK_LOW: next_rd_data[7:0] = pin_change_mask_low;
      default: next_rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req & ~wb_we_i) ? next_rd_data : 32'h0000_0000;
    end
  end

  // Plain read/write control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      external_line_mask <= `RST_EXT;
      external_sense_control <= `RST_SENSE;
      pin_change_group_enable <= `RST_GROUPS;
      pin_change_mask_high <= `RST_BYTE;
      pin_change_mask_mid <= `RST_MASK_MID;
      pin_change_mask_low <= `RST_BYTE;
    end else if (bus_wr) begin
      unique case (bus_idx)
        `IDX_EXTERNAL_LINE_MASK: external_line_mask <= wr_byte[`EXT_LINES-1:0];
        `IDX_EXTERNAL_SENSE_CONTROL: external_sense_control <= wr_byte[3:0];
        `IDX_PIN_CHANGE_GROUP_ENABLE: pin_change_group_enable <= wr_byte[2:0];
        `IDX_PIN_CHANGE_MASK_HIGH: pin_change_mask_high <= wr_byte;
        `IDX_PIN_CHANGE_MASK_MID: pin_change_mask_mid <= wr_byte[6:0];
        `IDX_PIN_CHANGE_MASK_LOW: pin_change_mask_low <= wr_byte;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pin sampling
  // ------------------------------------------------------------
  // Pins are read straight, whatever drives them, so software may
  // raise interrupts by driving its own outputs
  logic [`EXT_LINES-1:0] ext_sample;
  logic [`EXT_LINES-1:0] ext_prev;
  logic [`PC_PINS-1:0] pc_sample;
  logic [`PC_PINS-1:0] pc_prev;
  logic [1:0] sample_valid;

  // Edges are judged only once two real samples exist, so a pin that is
  // high at reset release does not fake an edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_sample <= `RST_EXT;
      ext_prev <= `RST_EXT;
      pc_sample <= {`PC_PINS{1'b0}};
      pc_prev <= {`PC_PINS{1'b0}};
      sample_valid <= 2'h0;
    end else begin
      ext_sample <= {ext_line_one_i, ext_line_zero_i};
      ext_prev <= ext_sample;
      pc_sample <= pin_change_input_i;
      pc_prev <= pc_sample;
      sample_valid <= {sample_valid[0], 1'b1};
    end
  end

  // ------------------------------------------------------------
  // External lines
  // ------------------------------------------------------------
  logic [`EXT_LINES-1:0] ext_trig;
  logic [`EXT_LINES-1:0] ext_level_low;
  logic [`EXT_LINES-1:0] ext_clear;
  logic [`EXT_LINES-1:0] ext_entry;
  logic [`EXT_LINES-1:0] ext_request;

  assign ext_entry = {vector_entry_i.ext_line_one, vector_entry_i.ext_line_zero};

  for (genvar i = 0; i < `EXT_LINES; i++) begin : g_ext
    logic [1:0] sense;
    assign sense = external_sense_control[2*i+1:2*i];
    assign ext_level_low[i] = (sense == ext_pin_change_irq_pkg::SENSE_LOW_LEVEL);
    assign ext_trig[i] = sample_valid[1] & sense_trigger(sense, ext_sample[i], ext_prev[i]);
    assign ext_clear[i] = ext_entry[i] |
                          (bus_wr && bus_idx == `IDX_EXTERNAL_LINE_FLAGS && wr_byte[i]);
    // Level sensing asks for as long as the pin is low, with no flag
    assign ext_request[i] = (external_line_flags[i] | (ext_level_low[i] & ~ext_sample[i]))
                            & external_line_mask[i] & global_irq_enable_i;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        external_line_flags[i] <= 1'b0;
      end else if (ext_level_low[i]) begin
        external_line_flags[i] <= 1'b0;
      end else if (ext_trig[i]) begin
        external_line_flags[i] <= 1'b1;
      end else if (ext_clear[i]) begin
        external_line_flags[i] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Pin-change groups
  // ------------------------------------------------------------
  logic [`PC_PINS-1:0] pc_enabled;
  logic [`PC_PINS-1:0] pc_change;
  logic [`PC_GROUPS-1:0] pc_hit;
  logic [`PC_GROUPS-1:0] pc_clear;
  logic [`PC_GROUPS-1:0] pc_entry;
  logic [`PC_GROUPS-1:0] pc_request;

  // Input 15 has no mask bit and never contributes
  assign pc_enabled = {pin_change_mask_high, 1'b0, pin_change_mask_mid,
                       pin_change_mask_low};
  assign pc_change = (pc_sample ^ pc_prev) & pc_enabled & {`PC_PINS{sample_valid[1]}};
  assign pc_entry = {vector_entry_i.group_two_vector, vector_entry_i.group_one_vector,
                     vector_entry_i.group_zero_vector};

  for (genvar g = 0; g < `PC_GROUPS; g++) begin : g_pc
    assign pc_hit[g] = |pc_change[8*g+7:8*g];
    assign pc_clear[g] = pc_entry[g] |
                         (bus_wr && bus_idx == `IDX_PIN_CHANGE_FLAGS && wr_byte[g]);
    assign pc_request[g] = pin_change_flags[g] & pin_change_group_enable[g]
                           & global_irq_enable_i;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pin_change_flags[g] <= 1'b0;
      end else if (pc_hit[g]) begin
        pin_change_flags[g] <= 1'b1;
      end else if (pc_clear[g]) begin
        pin_change_flags[g] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Vector requests, one line per vector
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_request_o <= '0;
    end else begin
      irq_request_o.ext_line_zero <= ext_request[0];
      irq_request_o.ext_line_one <= ext_request[1];
      irq_request_o.group_zero_vector <= pc_request[0];
      irq_request_o.group_one_vector <= pc_request[1];
      irq_request_o.group_two_vector <= pc_request[2];
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  logic last_rd;
  logic [7:0] last_idx;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_rd <= 1'b0;
      last_idx <= 8'h00;
    end else begin
      last_rd <= bus_req & ~wb_we_i;
      last_idx <= bus_idx;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_reserved_zero;
    (wb_ack_o && last_rd && (last_idx == `IDX_PIN_CHANGE_FLAGS
      || last_idx == `IDX_PIN_CHANGE_GROUP_ENABLE)) |-> wb_dat_o[31:3] == 29'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits of control or flag register read nonzero");

  property p_line_one_gate;
    irq_request_o.ext_line_one |-> $past(external_line_mask[1] && global_irq_enable_i);
  endproperty
  a_line_one_gate: assert property (p_line_one_gate)
    else $error("line one request without mask and global enable");

  property p_line_zero_gate;
    irq_request_o.ext_line_zero |-> $past(external_line_mask[0] && global_irq_enable_i);
  endproperty
  a_line_zero_gate: assert property (p_line_zero_gate)
    else $error("line zero request without mask and global enable");

  property p_falling_sets;
    (sample_valid[1] && external_sense_control[1:0] == 2'h2 && ext_prev[0] && !ext_sample[0])
      |=> external_line_flags[0];
  endproperty
  a_falling_sets: assert property (p_falling_sets)
    else $error("falling edge on line zero did not set its flag");

  property p_flag_set;
    ext_trig[1] |=> external_line_flags[1] ##1 (irq_request_o.ext_line_one
      || !$past(external_line_mask[1] && global_irq_enable_i));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("line one trigger lost or request missing");

  property p_vector_raised;
    (pin_change_flags[2] && pin_change_group_enable[2] && global_irq_enable_i)
      |=> irq_request_o.group_two_vector;
  endproperty
  a_vector_raised: assert property (p_vector_raised)
    else $error("group two request missing");

  property p_entry_clears;
    (vector_entry_i.group_zero_vector && !pc_hit[0]) |=> !pin_change_flags[0];
  endproperty
  a_entry_clears: assert property (p_entry_clears)
    else $error("vector entry did not clear group zero flag");

  property p_write_one_clears;
    (bus_wr && bus_idx == `IDX_EXTERNAL_LINE_FLAGS && wr_byte[1] && !ext_trig[1])
      |=> !external_line_flags[1];
  endproperty
  a_write_one_clears: assert property (p_write_one_clears)
    else $error("write of one did not clear line one flag");

  property p_level_flag_zero;
    ($past(ext_level_low[0]) && ext_level_low[0]) |-> !external_line_flags[0];
  endproperty
  a_level_flag_zero: assert property (p_level_flag_zero)
    else $error("line zero flag set under level sensing");

  property p_group_sets;
    pc_hit[1] |=> pin_change_flags[1];
  endproperty
  a_group_sets: assert property (p_group_sets)
    else $error("pin change did not set group one flag");

  property p_level_holds;
    (ext_level_low[0] && !ext_sample[0] && external_line_mask[0] && global_irq_enable_i)[*3]
      |=> irq_request_o.ext_line_zero;
  endproperty
  a_level_holds: assert property (p_level_holds)
    else $error("low level on line zero stopped requesting");

  property p_set_wins;
    (pc_hit[0] && pc_clear[0]) |=> pin_change_flags[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a simultaneous set");

  property p_ack_single;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single)
    else $error("ack held for more than one cycle");

  c_line_zero_req: cover property (irq_request_o.ext_line_zero);
  c_group_two_req: cover property (irq_request_o.group_two_vector);
  c_set_and_clear: cover property (pc_hit[0] && pc_clear[0]);
  c_level_req: cover property (ext_level_low[1] && irq_request_o.ext_line_one);

endmodule : ext_pin_change_irq

`default_nettype wire

// >>> tb/pin_source.sv
// Pin-side model: drives the external lines and the pin-change inputs
`timescale 1ns/100ps
`default_nettype none

module pin_source (
  // Clock
  input wire logic clk_i,
  // Commands from the bench
  input wire logic load_i,
  input wire logic [25:0] level_i,
  // Pins
  output logic ext_line_zero_o,
  output logic ext_line_one_o,
  output logic [23:0] pin_change_o
);
  // Levels move only on a clock edge, so every pulse lasts at least one period
  always_ff @(posedge clk_i) begin
    if (load_i) begin
      {ext_line_one_o, ext_line_zero_o, pin_change_o} <= level_i;
    end
  end
endmodule : pin_source

`default_nettype wire

// >>> tb/ext_pin_change_irq_bench.sv
// Self-checking bench for the external and pin-change interrupt block
`timescale 1ns/100ps
`default_nettype none
`include "ext_pin_change_irq_defines.svh"

module ext_pin_change_irq_bench;
  logic clk_i, rst_i, cyc, stb, we, ack, gie, load, ext0, ext1;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [25:0] lvl;
  logic [23:0] pc;
  ext_pin_change_irq_pkg::irq_vec_t vec, req;
  int n_fail, checks;

  ext_pin_change_irq ext_pin_change_irq_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .global_irq_enable_i(gie), .vector_entry_i(vec),
    .irq_request_o(req), .ext_line_zero_i(ext0), .ext_line_one_i(ext1),
    .pin_change_input_i(pc));
  pin_source pin_source_i (.clk_i(clk_i), .load_i(load), .level_i(lvl),
    .ext_line_zero_o(ext0), .ext_line_one_o(ext1), .pin_change_o(pc));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Classic cycle: hold everything until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [7:0] q);
    {cyc, stb, we} <= {2'b11, w};
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    q = rdat[7:0];
    {cyc, stb, we} <= 3'h0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(what, exp, q);
  endtask : rdc

  // Flip one pin, then let sample, flag and request settle
  task automatic tog(input int b);
    lvl <= lvl ^ (26'h1 << b);
    load <= 1'b1;
    @(posedge clk_i);
    load <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask : tog

  task automatic report_and_stop();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [7:0] ix [9] = '{`IDX_EXTERNAL_LINE_FLAGS, `IDX_PIN_CHANGE_FLAGS,
      `IDX_EXTERNAL_LINE_MASK, `IDX_PIN_CHANGE_GROUP_ENABLE, `IDX_EXTERNAL_SENSE_CONTROL,
      `IDX_PIN_CHANGE_MASK_LOW, `IDX_PIN_CHANGE_MASK_MID, `IDX_PIN_CHANGE_MASK_HIGH, 8'h10};
    logic [7:0] ex [9] = '{8'h00, 8'h00, 8'h03, 8'h07, 8'h0F, 8'hFF, 8'h7F, 8'hFF, 8'h00};
    chk("reset requests", 8'h00, {3'h0, req});
    foreach (ix[i]) begin
      rdc("reset value", ix[i], 8'h00);
      wr(ix[i], 8'hFF);
      rdc("writable bits", ix[i], ex[i]);
      wr(ix[i], 8'h00);
    end
    $display("test registers done");
  endtask : t_regs

  task automatic t_groups();
    int pin [3] = '{3, 9, 20};
    logic [7:0] mreg [3] = '{`IDX_PIN_CHANGE_MASK_LOW, `IDX_PIN_CHANGE_MASK_MID,
      `IDX_PIN_CHANGE_MASK_HIGH};
    logic [7:0] mval [3] = '{8'h08, 8'h02, 8'h10};
    gie <= 1'b1;
    wr(`IDX_PIN_CHANGE_GROUP_ENABLE, 8'h07);
    for (int g = 0; g < 3; g++) begin
      wr(mreg[g], mval[g]);
      tog(pin[g] ^ 1);
      rdc("masked pin flag", `IDX_PIN_CHANGE_FLAGS, 8'h00);
      tog(pin[g]);
      rdc("group flag", `IDX_PIN_CHANGE_FLAGS, 8'h01 << g);
      chk("group request", 8'h04 << g, {3'h0, req});
      gie <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("request without global", 8'h00, {3'h0, req});
      gie <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("request with global", 8'h04 << g, {3'h0, req});
      wr(`IDX_PIN_CHANGE_GROUP_ENABLE, 8'h07 ^ (8'h01 << g));
      chk("request without group enable", 8'h00, {3'h0, req});
      wr(`IDX_PIN_CHANGE_GROUP_ENABLE, 8'h07);
      vec <= ext_pin_change_irq_pkg::irq_vec_t'(5'h04 << g);
      @(posedge clk_i);
      vec <= '0;
      repeat (3) @(posedge clk_i);
      rdc("flag after entry", `IDX_PIN_CHANGE_FLAGS, 8'h00);
      chk("request after entry", 8'h00, {3'h0, req});
      wr(mreg[g], 8'h00);
    end
    // Pin change lands on the same edge as the write-one clear
    wr(`IDX_PIN_CHANGE_MASK_LOW, 8'h08);
    lvl <= lvl ^ 26'h0000008;
    load <= 1'b1;
    @(posedge clk_i);
    load <= 1'b0;
    @(posedge clk_i);
    wr(`IDX_PIN_CHANGE_FLAGS, 8'h01);
    rdc("flag after set and clear", `IDX_PIN_CHANGE_FLAGS, 8'h01);
    wr(`IDX_PIN_CHANGE_FLAGS, 8'h01);
    wr(`IDX_PIN_CHANGE_MASK_LOW, 8'h00);
    $display("test groups done");
  endtask : t_groups

  task automatic t_edges();
    wr(`IDX_EXTERNAL_LINE_MASK, 8'h03);
    for (int l = 0; l < 2; l++) begin
      for (int c = 1; c < 4; c++) begin
        wr(`IDX_EXTERNAL_SENSE_CONTROL, 8'(c << (2 * l)));
        wr(`IDX_EXTERNAL_LINE_FLAGS, 8'h03);
        tog(24 + l);
        rdc("rise flag", `IDX_EXTERNAL_LINE_FLAGS, (c != 2) ? 8'h01 << l : 8'h00);
        chk("line request", {7'h0, c != 2}, {7'h0, req[l]});
        vec <= ext_pin_change_irq_pkg::irq_vec_t'(5'h01 << l);
        @(posedge clk_i);
        vec <= '0;
        rdc("flag after line entry", `IDX_EXTERNAL_LINE_FLAGS, 8'h00);
        tog(24 + l);
        rdc("fall flag", `IDX_EXTERNAL_LINE_FLAGS, (c != 3) ? 8'h01 << l : 8'h00);
        wr(`IDX_EXTERNAL_LINE_FLAGS, 8'h00);
        rdc("flag after zero", `IDX_EXTERNAL_LINE_FLAGS, (c != 3) ? 8'h01 << l : 8'h00);
        wr(`IDX_EXTERNAL_LINE_FLAGS, 8'h03);
        rdc("flag after one", `IDX_EXTERNAL_LINE_FLAGS, 8'h00);
      end
    end
    $display("test edges done");
  endtask : t_edges

  task automatic t_level();
    // Leave a line one flag set, so the switch to level sensing must drop it
    tog(25);
    tog(25);
    wr(`IDX_EXTERNAL_SENSE_CONTROL, 8'h00);
    repeat (3) @(posedge clk_i);
    chk("level requests", 8'h03, {3'h0, req});
    rdc("level flag", `IDX_EXTERNAL_LINE_FLAGS, 8'h00);
    tog(24);
    chk("line high", 8'h02, {3'h0, req});
    tog(24);
    wr(`IDX_EXTERNAL_LINE_MASK, 8'h02);
    repeat (3) @(posedge clk_i);
    chk("line zero masked", 8'h02, {3'h0, req});
    wr(`IDX_EXTERNAL_LINE_MASK, 8'h01);
    repeat (3) @(posedge clk_i);
    chk("line one masked", 8'h01, {3'h0, req});
    gie <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("global off", 8'h00, {3'h0, req});
    $display("test level done");
  endtask : t_level

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    report_and_stop();
  end

  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, gie} = 4'h0;
    adr = 10'h000;
    sel = 4'hF;
    wdat = 32'h00000000;
    vec = '0;
    lvl = 26'h0000000;
    load = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    load <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_regs();
    t_groups();
    t_edges();
    t_level();
    report_and_stop();
  end
endmodule : ext_pin_change_irq_bench

`default_nettype wire
